// *** rtl/temp_sensor_cfg.svh ***
// Constants for the temperature sensor conversion and serial readout block.
// Assumes a 25 MHz system clock and a serial shift clock from an outside master.
//
// Summary of operation
// - Select high enables shift clock; low ignores it
// - Shift clock moves result out, control in
// - Output carries result bits; input carries control
// - Conversion timing from internal clock only
// - New conversion starts every 400 us
// - Conversion takes 25 us, then converter sleeps
// - Latest result readable at any moment
// - Shutdown stops oscillator and further conversions
// - Shutdown keeps last result for reads
// - End of access restarts conversion sequence only when idle, not mid-conversion
// - Leaving shutdown restarts conversion at once
// - Result changes on conversion completion; one done mid-frame lands at select low
// - Result is read-only 10-bit twos complement
// - Quarter degree per code step
// - Sixteen clocks: leading zero, ten result bits
// - Control loads on 15th rising edge only
// - Third written bit is the shutdown control
// - Output holds last bit, floats when deselected
`ifndef TEMP_SENSOR_CFG_SVH
`define TEMP_SENSOR_CFG_SVH

// ==========================================================
// Timing
`define TS_CLK_MHZ      25
`define TS_PERIOD_US    400
`define TS_CONV_US      25
`define TS_PERIOD_CYC   (`TS_PERIOD_US * `TS_CLK_MHZ)
`define TS_CONV_CYC     (`TS_CONV_US * `TS_CLK_MHZ)
`define TS_CNT_W        14

// ==========================================================
// Result word
`define TS_RESULT_W     10
`define TS_RESULT_RST   10'h000

// ==========================================================
// Serial frame edge indices (count of edges already seen)
`define TS_EDGE_W       5
`define TS_LEAD_EDGE    5'h00
`define TS_MSB_EDGE     5'h01
`define TS_LOAD_EDGE    5'h0e
`define TS_PD_FALL      5'h02
`define TS_EDGE_MAX     5'h1f

`endif

// *** rtl/temp_sensor_pkg.sv ***
// Types shared by the temperature sensor block.
// Assumes nothing of its surroundings.
package temp_sensor_pkg;

    // Conversion sequencer states, Gray coded along idle, convert, shutdown
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_SHUT = 2'h3
    } conv_state_t;

endpackage : temp_sensor_pkg

// *** rtl/level_sync.sv ***
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit changes slowly compared with the receiving clock.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ==========================================================
    // Parameter check
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("level_sync needs WIDTH of one or more");
        end
    endgenerate

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ==========================================================
    // Two flops per bit; first stage feeds only the second
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge clock_i) begin
                if (!rst_b_i) begin
                    meta_q[b] <= 1'b0;
                    sync_q[b] <= 1'b0;
                end else begin
                    meta_q[b] <= async_i[b];
                    sync_q[b] <= meta_q[b];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule : level_sync

`default_nettype wire

// *** rtl/temp_sensor.sv ***
// Temperature sensor digital side: conversion sequencer and serial port.
// Assumes a free-running 25 MHz system clock, an analog converter whose
// output code is steady on conv_code_i while converter_awake_o is high,
// and a serial master whose shift clock stands still outside frames.
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_cfg.svh"

module temp_sensor #(
    parameter int RESULT_W   = `TS_RESULT_W,
    parameter int CNT_W      = `TS_CNT_W,
    parameter int PERIOD_CYC = `TS_PERIOD_CYC,
    parameter int CONV_CYC   = `TS_CONV_CYC
) (
    input  wire logic                clock_i,
    input  wire logic                rst_b_i,
    input  wire logic [RESULT_W-1:0] conv_code_i,
    input  wire logic                select_i,
    input  wire logic                shift_clk_i,
    input  wire logic                serial_in_line_i,
    output logic                     serial_out_line_o,
    output logic                     serial_out_oe_o,
    output logic                     converter_awake_o,
    output logic                     shutdown_o
);

    // ==========================================================
    // Parameter checks
    generate
        if (RESULT_W < 2 || RESULT_W > 14) begin : g_bad_result
            $error("temp_sensor RESULT_W must lie in 2..14");
        end
        if (CONV_CYC < 1 || PERIOD_CYC <= CONV_CYC || PERIOD_CYC > (1 << CNT_W)) begin : g_bad_timing
            $error("temp_sensor timing counts do not fit the counter");
        end
    endgenerate

    localparam logic [CNT_W-1:0]      CONV_LAST   = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0]      PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [`TS_EDGE_W-1:0] LAST_EDGE   = `TS_EDGE_W'(RESULT_W);

    // ==========================================================
    // System domain declarations
    temp_sensor_pkg::conv_state_t state_q;
    temp_sensor_pkg::conv_state_t state_d;

    logic [CNT_W-1:0]    cnt_q;
    logic [CNT_W-1:0]    cnt_d;
    logic [RESULT_W-1:0] temp_reading_q;
    logic [RESULT_W-1:0] pend_result_q;
    logic                pend_q;
    logic                shutdown_q;
    logic                awake_q;
    logic                sel_prev_q;
    logic                tog_prev_q;
    logic [1:0]          sync_vec;
    logic                sel_s;
    logic                tog_s;

    // ==========================================================
    // Link domain declarations
    // Crossing hazards and how they are met:
    // - select_i and the load toggle reach the system side through
    //   two flops each, so only levels cross, never pulses.
    // - pd_hold_q is read by the system side only after the toggle
    //   has been synchronised, and it is not touched again until
    //   the next frame's fifteenth edge.
    // - temp_reading_q is read by the link side on the second rising
    //   edge. The system side leaves it alone while the synchronised
    //   select is high, so the word is steady by then, provided the
    //   master keeps a few system clocks between select and that edge.
    // Limitation: the shift clock must stand still outside frames.
    logic [`TS_EDGE_W-1:0] rise_cnt_q;
    logic [`TS_EDGE_W-1:0] fall_cnt_q;
    logic [RESULT_W-1:0]   shift_q;
    logic                  sdo_q;
    logic                  oe_q;
    logic                  pd_sample_q;
    logic                  pd_hold_q;
    logic                  load_tog_q;

    // ==========================================================
    // Crossings into the system domain
    level_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i ({load_tog_q, select_i}),
        .sync_o  (sync_vec)
    );

    assign sel_s = sync_vec[0];
    assign tog_s = sync_vec[1];

    // Event decode from synchronised levels and cnt_q
    wire frame_end   = sel_prev_q & ~sel_s;
    wire ctrl_load   = tog_s ^ tog_prev_q;
    wire period_done = (cnt_q == PERIOD_LAST);
    wire conv_done   = (cnt_q == CONV_LAST);
    wire result_free = ~sel_s;

    // Sequencer state flags
    wire in_idle = (state_q == temp_sensor_pkg::ST_IDLE);
    wire in_conv = (state_q == temp_sensor_pkg::ST_CONV);

    // ==========================================================
    // Conversion sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + CNT_W'(1);
        case (state_q)
            temp_sensor_pkg::ST_IDLE: begin
                if (shutdown_q) begin
                    state_d = temp_sensor_pkg::ST_SHUT;
                    cnt_d   = '0;
                end else if (frame_end) begin
                    state_d = temp_sensor_pkg::ST_CONV;
                    cnt_d   = '0;
                end else if (period_done) begin
                    state_d = temp_sensor_pkg::ST_CONV;
                    cnt_d   = '0;
                end
            end
            temp_sensor_pkg::ST_CONV: begin
                if (shutdown_q) begin
                    state_d = temp_sensor_pkg::ST_SHUT;
                    cnt_d   = '0;
                end else if (conv_done) begin
                    state_d = temp_sensor_pkg::ST_IDLE;
                end
            end
            temp_sensor_pkg::ST_SHUT: begin
                cnt_d = '0;
                if (!shutdown_q) begin
                    state_d = temp_sensor_pkg::ST_CONV;
                end
            end
            default: begin
                state_d = temp_sensor_pkg::ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers, timed by the system clock
    // Internal conversion clock
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_q <= temp_sensor_pkg::ST_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Edge memories for the synchronised levels
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sel_prev_q <= 1'b0;
            tog_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_s;
            tog_prev_q <= tog_s;
        end
    end

    // ==========================================================
    // Shutdown control, loaded from the serial frame
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            shutdown_q <= 1'b0;
        end else if (ctrl_load) begin
            shutdown_q <= pd_hold_q;
        end
    end

    // Converter wake strobe, high while converting
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            awake_q <= 1'b0;
        end else begin
            awake_q <= (state_d == temp_sensor_pkg::ST_CONV);
        end
    end

    // ==========================================================
    // Result capture; a result finished mid-frame waits for select low
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            temp_reading_q <= `TS_RESULT_RST;
            pend_result_q  <= `TS_RESULT_RST;
            pend_q         <= 1'b0;
        end else begin
            // Shutdown keeps last result
            // An aborted conversion never reaches this branch, so the
            // word read back in shutdown is the last complete one.
            if (in_conv && conv_done && !shutdown_q) begin
                // Quarter-degree steps kept unscaled
                // The code is stored exactly as the converter gives it;
                // any scaling to degrees is left to the reader.
                if (result_free) begin
                    temp_reading_q <= conv_code_i;
                    pend_q         <= 1'b0;
                end else begin
                    pend_result_q <= conv_code_i;
                    pend_q        <= 1'b1;
                end
            end else if (pend_q && result_free) begin
                temp_reading_q <= pend_result_q;
                pend_q         <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Link domain: rising edges drive the output line
    // Select low clears the port
    always_ff @(posedge shift_clk_i or negedge select_i) begin
        if (!select_i) begin
            rise_cnt_q <= `TS_LEAD_EDGE;
        end else if (rise_cnt_q != `TS_EDGE_MAX) begin
            rise_cnt_q <= rise_cnt_q + `TS_EDGE_W'(1);
        end
    end

    // Output shifter; result word is steady while select is high
    // Leading zero then result
    always_ff @(posedge shift_clk_i or negedge select_i) begin
        if (!select_i) begin
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
            shift_q <= '0;
        end else if (rise_cnt_q == `TS_LEAD_EDGE) begin
            sdo_q <= 1'b0;
            oe_q  <= 1'b1;
        end else if (rise_cnt_q == `TS_MSB_EDGE) begin
            sdo_q   <= temp_reading_q[RESULT_W-1];
            shift_q <= {temp_reading_q[RESULT_W-2:0], 1'b0};
        end else if (rise_cnt_q <= LAST_EDGE) begin
            sdo_q   <= shift_q[RESULT_W-1];
            shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
        end
    end

    // ==========================================================
    // Link domain: falling edges sample the input line
    always_ff @(negedge shift_clk_i or negedge select_i) begin
        if (!select_i) begin
            fall_cnt_q  <= `TS_LEAD_EDGE;
            pd_sample_q <= 1'b0;
        end else begin
            if (fall_cnt_q != `TS_EDGE_MAX) begin
                fall_cnt_q <= fall_cnt_q + `TS_EDGE_W'(1);
            end
            if (fall_cnt_q == `TS_PD_FALL) begin
                pd_sample_q <= serial_in_line_i;
            end
        end
    end

    // Control load on the 15th rising edge; toggle tells the system side
    // A toggle rather than a pulse is used because the shift clock may
    // stop right after the load; a pulse could be missed by the system
    // clock, a level change cannot.
    always_ff @(posedge shift_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_hold_q  <= 1'b0;
            load_tog_q <= 1'b0;
        end else if (select_i && rise_cnt_q == `TS_LOAD_EDGE) begin
            pd_hold_q  <= pd_sample_q;
            load_tog_q <= ~load_tog_q;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign serial_out_line_o = sdo_q;
    assign serial_out_oe_o   = oe_q;
    assign converter_awake_o = awake_q;
    assign shutdown_o        = shutdown_q;

endmodule : temp_sensor

`default_nettype wire

// *** testbench/temp_sensor_props.sv ***
// Concurrent checks on the temperature sensor top-level ports.
// Assumes it is bound to temp_sensor with the same timing parameters.
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_props #(
    parameter int RESULT_W   = 10,
    parameter int PERIOD_CYC = 200,
    parameter int CONV_CYC   = 20
) (
    input wire logic                clock_i,
    input wire logic                rst_b_i,
    input wire logic [RESULT_W-1:0] conv_code_i,
    input wire logic                select_i,
    input wire logic                shift_clk_i,
    input wire logic                serial_in_line_i,
    input wire logic                serial_out_line_o,
    input wire logic                serial_out_oe_o,
    input wire logic                converter_awake_o,
    input wire logic                shutdown_o
);
    // ==========================================================
    // Helper counters
    logic [15:0] awake_cnt_q;
    logic [15:0] idle_cnt_q;

    // Length of the awake pulse and of the quiet gap between starts
    always_ff @(posedge clock_i) begin
        awake_cnt_q <= (!rst_b_i || !converter_awake_o) ? 16'h0000 : awake_cnt_q + 16'h0001;
        idle_cnt_q  <= (!rst_b_i || converter_awake_o || shutdown_o || select_i) ? 16'h0000 : idle_cnt_q + 16'h0001;
    end

    // ==========================================================
    // Assertions
    a_oe_off_desel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !select_i |-> !serial_out_oe_o) else $error("output enabled while deselected");
    a_lead_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(serial_out_oe_o) |-> !serial_out_line_o) else $error("first bit not zero");
    a_oe_in_frame: assert property (@(negedge shift_clk_i) disable iff (!rst_b_i)
        select_i |-> serial_out_oe_o) else $error("output not driven in frame");
    a_conv_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(converter_awake_o) && !shutdown_o |-> awake_cnt_q >= CONV_CYC - 1 && awake_cnt_q <= CONV_CYC)
        else $error("conversion length wrong");
    a_start_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        idle_cnt_q <= PERIOD_CYC + 2) else $error("periodic start missing");
    a_shut_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        shutdown_o && $past(shutdown_o, 2) |-> !converter_awake_o) else $error("converting in shutdown");
    a_leave_shut: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(shutdown_o) |-> ##[1:4] converter_awake_o) else $error("no start on wake");
    a_frame_conv: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(select_i) |-> ##[1:8] (converter_awake_o || shutdown_o)) else $error("no start after access");

    // Main scenarios reached
    c_shut_on: cover property (@(posedge clock_i) $rose(shutdown_o));
    c_shut_off: cover property (@(posedge clock_i) $fell(shutdown_o));
    c_conv_done: cover property (@(posedge clock_i) $fell(converter_awake_o));
endmodule : temp_sensor_props

bind temp_sensor temp_sensor_props #(.RESULT_W(RESULT_W), .PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) u_props (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .conv_code_i(conv_code_i), .select_i(select_i),
    .shift_clk_i(shift_clk_i), .serial_in_line_i(serial_in_line_i), .serial_out_line_o(serial_out_line_o),
    .serial_out_oe_o(serial_out_oe_o), .converter_awake_o(converter_awake_o), .shutdown_o(shutdown_o));
`default_nettype wire

// *** testbench/serial_master_model.sv ***
// Serial master model that frames reads and control writes.
// Assumes the bench calls frame and resolves nothing else on the link.
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
    input  wire logic line_i,
    input  wire logic oe_i,
    output logic      select_o,
    output logic      shift_clk_o,
    output logic      data_o
);
    // Link idle: deselected, clock parked low
    initial begin
        select_o = 1'b0;
        shift_clk_o = 1'b0;
        data_o = 1'b1;
    end

    // select first, count clocks, third bit control
    task automatic frame(input logic pd, input int n_rise, output logic [15:0] rd);
        rd = 16'hffff;
        #13;
        select_o = 1'b1;
        #160;
        for (int i = 1; i <= n_rise; i++) begin
            shift_clk_o = 1'b1;
            data_o = (i < 3) ? 1'b1 : ((i == 3) ? pd : 1'b0); // Leading bits are don't care
            #80;
            shift_clk_o = 1'b0;
            rd[16-i] = oe_i ? line_i : 1'bx; // Floating line never matches
            #80;
        end
        select_o = 1'b0;
        data_o = 1'b1;
        #200;
    endtask : frame
endmodule : serial_master_model
`default_nettype wire

// *** testbench/temp_sensor_conversion_readout_tb_top.sv ***
// Self-checking bench: conversions, serial reads and shutdown control.
// Assumes shortened timing parameters and the serial master model.
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_conversion_readout_tb_top;
    typedef struct packed { logic [9:0] code; logic [15:0] word; } row_t;
    localparam row_t ROWS [4] = '{'{10'h200, 16'h4000}, '{10'h001, 16'h003f}, '{10'h1fc, 16'h3f80},
                                  '{10'h3ff, 16'h7fff}};
    logic        clock_i;
    logic        rst_b_i;
    logic [9:0]  conv_code_i;
    wire logic   select_w, shift_clk_w, data_w, line_w, oe_w, awake_w, shutdown_w;
    logic [15:0] rd;
    logic        seen;
    int          n_mismatch = 0;
    int          compares = 0;

    // ==========================================================
    // Design and far side
    temp_sensor #(.PERIOD_CYC(200), .CONV_CYC(20)) temp_sensor_i (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .conv_code_i(conv_code_i), .select_i(select_w),
        .shift_clk_i(shift_clk_w), .serial_in_line_i(data_w), .serial_out_line_o(line_w),
        .serial_out_oe_o(oe_w), .converter_awake_o(awake_w), .shutdown_o(shutdown_w));
    serial_master_model serial_master_model_i (
        .line_i(line_w), .oe_i(oe_w), .select_o(select_w), .shift_clk_o(shift_clk_w), .data_o(data_w));

    // System clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // ==========================================================
    // Helpers
    task automatic results();
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wait_for(input logic want);
        for (int n = 0; n < 400; n++) begin
            if (awake_w === want) return;
            @(posedge clock_i);
        end
        check("awake_wait", {15'h0, want}, {15'h0, awake_w});
        results();
    endtask : wait_for

    // ==========================================================
    // Main sequence
    initial begin
        rst_b_i = 1'b0;
        conv_code_i = 10'h000;
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check("reset_state", 16'h0000, {13'h0, shutdown_w, awake_w, oe_w});
        foreach (ROWS[k]) begin
            conv_code_i <= ROWS[k].code;
            wait_for(1'b1);
            wait_for(1'b0);
            serial_master_model_i.frame(1'b0, 16, rd);
            check("read_word", ROWS[k].word, rd);
        end
        serial_master_model_i.frame(1'b1, 16, rd);
        check("read_to_shut", 16'h7fff, rd);
        repeat (8) @(posedge clock_i);
        check("shut_set", 16'h0001, {15'h0, shutdown_w});
        conv_code_i <= 10'h0c8;
        seen = 1'b0;
        repeat (300) @(posedge clock_i) seen = seen | (awake_w !== 1'b0);
        check("shut_quiet", 16'h0000, {15'h0, seen});
        serial_master_model_i.frame(1'b1, 16, rd);
        check("read_in_shut", 16'h7fff, rd);
        serial_master_model_i.frame(1'b0, 10, rd);
        repeat (8) @(posedge clock_i);
        check("short_frame", 16'h0001, {15'h0, shutdown_w});
        serial_master_model_i.frame(1'b0, 16, rd);
        check("read_at_wake", 16'h7fff, rd);
        wait_for(1'b1);
        wait_for(1'b0);
        serial_master_model_i.frame(1'b0, 16, rd);
        check("read_after_wake", 16'h1900, rd);
        results();
    end
endmodule : temp_sensor_conversion_readout_tb_top
`default_nettype wire
